/* File: logic/seg_offset_pkg.sv */
// Constants and types for the waveform segment time offset block
// How it works
// [RL1] Overdrive segment length shifted by overdrive offset
// [RL2] Overdrive is the largest sample in waveform
// [RL3] Overdrive offset used only in open loop
// [RL4] Overdrive offset signed, scaled by step period
// [RL5] Other positive segments take positive sustain offset
// [RL6] Positive sustain offset is signed two's complement
// [RL7] Other negative segments take negative sustain offset
// [RL8] Negative sustain offset signed, scaled by step
// [RL9] Brake is most negative sample, brake offset
// [RL10] Brake offset used only in open loop
// [RL11] Brake offset signed, scaled by step period
// [RL12] Negative result clamps segment to zero length
// [RL13] Positive sustain uses same step scaling
`default_nettype none
package seg_offset_pkg;
  localparam logic [7:0] ADDR_OVERDRIVE = 8'h0d;
  localparam logic [7:0] ADDR_POS_SUST  = 8'h0e;
  localparam logic [7:0] ADDR_NEG_SUST  = 8'h0f;
  localparam logic [7:0] ADDR_BRAKE     = 8'h10;
  localparam logic [7:0] OFFSET_RESET   = 8'h00;
  localparam logic [7:0] UNMAPPED_READ  = 8'h00;
  localparam int         SEG_DEPTH      = 16;
  localparam logic [8:0] ONE_STEP       = 9'h001;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_FETCH = 4'h2,
    ST_CALC  = 4'h4,
    ST_HOLD  = 4'h8
  } seg_state_type;

  typedef enum logic [2:0] {
    KIND_NONE      = 3'h0,
    KIND_OVERDRIVE = 3'h1,
    KIND_POS_SUST  = 3'h2,
    KIND_NEG_SUST  = 3'h3,
    KIND_BRAKE     = 3'h4
  } seg_kind_type;
endpackage : seg_offset_pkg
`default_nettype wire

/* File: logic/seg_store.sv */
// Segment memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module seg_store #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             rd_en,
  input  wire logic [AW-1:0]    rd_addr,
  output var  logic [WIDTH-1:0] rd_data_q
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] rd_data_d;

  always_comb begin
    rd_data_d = rd_en ? mem[rd_addr] : rd_data_q;
  end

  // No reset on the array itself, it is always written before read
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rd_data_q <= '0;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end
endmodule : seg_store
`default_nettype wire

/* File: logic/segment_time_offsets.sv */
// Segment time offset registers and open-loop segment timing engine
`timescale 1ns/1ns
`default_nettype none
module segment_time_offsets
  import seg_offset_pkg::*;
#(
  parameter int DEPTH = SEG_DEPTH
) (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [7:0]  reg_rdata,
  output var  logic        reg_rvalid,
  input  wire logic        open_loop,
  input  wire logic [15:0] step_cycles,
  input  wire logic        seg_valid,
  output var  logic        seg_ready,
  input  wire logic [7:0]  seg_level,
  input  wire logic [7:0]  seg_steps,
  input  wire logic        seg_last,
  output var  logic        drive_active,
  output var  logic [7:0]  drive_level,
  output var  logic [2:0]  drive_kind,
  output var  logic        play_done
);
  localparam int AW = $clog2(DEPTH);

  // Register file
  logic [7:0] od_q, od_d, ps_q, ps_d, ns_q, ns_d, br_q, br_d;
  logic [7:0] rdata_q, rdata_d;
  logic       rvalid_q, rvalid_d;

  always_comb begin
    od_d     = od_q;
    ps_d     = ps_q;
    ns_d     = ns_q;
    br_d     = br_q;
    rvalid_d = reg_rd;
    rdata_d  = rdata_q;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_OVERDRIVE: od_d = reg_wdata;
        ADDR_POS_SUST:  ps_d = reg_wdata;
        ADDR_NEG_SUST:  ns_d = reg_wdata;
        ADDR_BRAKE:     br_d = reg_wdata;
        default:        od_d = od_q;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        ADDR_OVERDRIVE: rdata_d = od_q;
        ADDR_POS_SUST:  rdata_d = ps_q;
        ADDR_NEG_SUST:  rdata_d = ns_q;
        ADDR_BRAKE:     rdata_d = br_q;
        default:        rdata_d = UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      od_q     <= OFFSET_RESET;
      ps_q     <= OFFSET_RESET;
      ns_q     <= OFFSET_RESET;
      br_q     <= OFFSET_RESET;
      rdata_q  <= UNMAPPED_READ;
      rvalid_q <= 1'b0;
    end else begin
      od_q     <= od_d;
      ps_q     <= ps_d;
      ns_q     <= ns_d;
      br_q     <= br_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign reg_rdata  = rdata_q;
  assign reg_rvalid = rvalid_q;

  // Segment storage; the whole waveform is seen before playback
  // because peak and minimum are only known once it is all loaded
  logic          wr_en;
  logic          rd_en;
  logic [15:0]   rd_word;
  logic [AW:0]   count_q, count_d;
  logic [AW:0]   idx_q, idx_d;

  seg_store #(.WIDTH(16), .DEPTH(DEPTH), .AW(AW)) u_store (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .wr_en     (wr_en),
    .wr_addr   (count_q[AW-1:0]),
    .wr_data   ({seg_level, seg_steps}),
    .rd_en     (rd_en),
    .rd_addr   (idx_q[AW-1:0]),
    .rd_data_q (rd_word)
  );

  // Sequencer state
  seg_state_type state_q, state_d;
  logic signed [7:0] max_q, max_d, min_q, min_d;
  logic [8:0]  left_q, left_d;
  logic [15:0] cyc_q, cyc_d;
  logic        ready_q, ready_d;
  logic        act_q, act_d;
  logic [7:0]  lvl_q, lvl_d;
  logic [2:0]  kind_q, kind_d;
  logic        done_q, done_d;
  logic        adv;

  logic signed [7:0] cur_level;
  logic [7:0]        cur_steps;
  seg_kind_type      cur_kind;
  logic [7:0]        off_sel;
  logic signed [9:0] sum_d;

  assign cur_level = $signed(rd_word[15:8]);
  assign cur_steps = rd_word[7:0];

  // Classify the fetched segment and pick its offset
  always_comb begin
    cur_kind = KIND_NONE;
    off_sel  = 8'h00;
    if (cur_level == max_q) begin
      cur_kind = KIND_OVERDRIVE; // [RL2]
      off_sel  = open_loop ? od_q : 8'h00; // [RL1] [RL3]
    end else if (cur_level == min_q) begin
      cur_kind = KIND_BRAKE; // [RL9]
      off_sel  = open_loop ? br_q : 8'h00; // [RL9] [RL10]
    end else if (cur_level > 0) begin
      cur_kind = KIND_POS_SUST; // [RL5]
      off_sel  = ps_q;
    end else if (cur_level < 0) begin
      cur_kind = KIND_NEG_SUST; // [RL7]
      off_sel  = ns_q;
    end
    // Offset is a signed count of step periods [RL4] [RL6] [RL8] [RL11] [RL13]
    sum_d = $signed({2'b00, cur_steps}) + $signed({{2{off_sel[7]}}, off_sel});
  end

  assign wr_en = (state_q == ST_IDLE) && seg_valid && ready_q && (count_q < (AW+1)'(DEPTH));
  assign rd_en = (state_q == ST_FETCH);

  always_comb begin
    state_d = state_q;
    count_d = count_q;
    idx_d   = idx_q;
    max_d   = max_q;
    min_d   = min_q;
    left_d  = left_q;
    cyc_d   = cyc_q;
    act_d   = act_q;
    lvl_d   = lvl_q;
    kind_d  = kind_q;
    done_d  = 1'b0;
    adv     = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (seg_valid && ready_q) begin
          if (wr_en) begin
            count_d = count_q + 1'b1;
          end
          if (count_q == '0 || $signed(seg_level) > max_q) begin
            max_d = $signed(seg_level);
          end
          if (count_q == '0 || $signed(seg_level) < min_q) begin
            min_d = $signed(seg_level);
          end
          if (seg_last) begin
            state_d = ST_FETCH;
            idx_d   = '0;
          end
        end
      end
      ST_FETCH: begin
        state_d = ST_CALC;
      end
      ST_CALC: begin
        if (sum_d > 0) begin
          state_d = ST_HOLD;
          left_d  = sum_d[8:0];
          cyc_d   = '0;
          act_d   = 1'b1;
          lvl_d   = cur_level;
          kind_d  = cur_kind;
        end else begin
          adv = 1'b1; // [RL12]
        end
      end
      ST_HOLD: begin
        if ({1'b0, cyc_q} + 17'h00001 >= {1'b0, step_cycles}) begin
          cyc_d = '0;
          if (left_q == ONE_STEP) begin
            act_d = 1'b0;
            adv   = 1'b1;
          end else begin
            left_d = left_q - ONE_STEP;
          end
        end else begin
          cyc_d = cyc_q + 16'h0001;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (adv) begin
      idx_d = idx_q + 1'b1;
      if (idx_q + 1'b1 >= count_q) begin
        state_d = ST_IDLE;
        count_d = '0;
        done_d  = 1'b1;
      end else begin
        state_d = ST_FETCH;
      end
    end
    ready_d = (state_d == ST_IDLE);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      count_q <= '0;
      idx_q   <= '0;
      max_q   <= '0;
      min_q   <= '0;
      left_q  <= '0;
      cyc_q   <= '0;
      ready_q <= 1'b1;
      act_q   <= 1'b0;
      lvl_q   <= 8'h00;
      kind_q  <= KIND_NONE;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
      idx_q   <= idx_d;
      max_q   <= max_d;
      min_q   <= min_d;
      left_q  <= left_d;
      cyc_q   <= cyc_d;
      ready_q <= ready_d;
      act_q   <= act_d;
      lvl_q   <= lvl_d;
      kind_q  <= kind_d;
      done_q  <= done_d;
    end
  end

  assign seg_ready    = ready_q;
  assign drive_active = act_q;
  assign drive_level  = lvl_q;
  assign drive_kind   = kind_q;
  assign play_done    = done_q;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence od_write;
    reg_wr && reg_addr == ADDR_OVERDRIVE;
  endsequence
  sequence od_read;
    !reg_wr && reg_rd && reg_addr == ADDR_OVERDRIVE;
  endsequence

  AST_OD_READBACK: assert property (od_write ##1 od_read |=> reg_rvalid && reg_rdata == $past(reg_wdata, 2)) // [RL4]
    else $error("overdrive offset readback mismatch");
  // Peak and minimum must bound every stored sample
  AST_OD_PEAK: assert property (state_q == ST_CALC // [RL2]
    |-> cur_level <= max_q && cur_level >= min_q && ((cur_kind == KIND_OVERDRIVE) == (cur_level == max_q)))
    else $error("overdrive segment is not the peak");
  AST_OD_OPEN: assert property (state_q == ST_CALC && cur_kind == KIND_OVERDRIVE && open_loop && sum_d > 0 // [RL1]
    |=> left_q == 9'($signed({2'b00, $past(cur_steps)}) + $signed({{2{od_q[7]}}, od_q})))
    else $error("overdrive length not adjusted");
  AST_OD_CLOSED: assert property (state_q == ST_CALC && cur_kind == KIND_OVERDRIVE && !open_loop // [RL3]
    && cur_steps != 8'h00 |=> left_q == {1'b0, $past(cur_steps)})
    else $error("overdrive offset used in closed loop");
  AST_BRK_MIN: assert property (state_q == ST_CALC && cur_kind == KIND_BRAKE // [RL9]
    |-> cur_level == min_q && cur_level != max_q)
    else $error("brake segment is not the minimum");
  AST_BRK_CLOSED: assert property (state_q == ST_CALC && cur_kind == KIND_BRAKE && !open_loop // [RL10]
    |-> sum_d == $signed({2'b00, cur_steps}))
    else $error("brake offset used in closed loop");
  AST_BRK_OPEN: assert property (state_q == ST_CALC && cur_kind == KIND_BRAKE && open_loop // [RL11]
    |-> sum_d == $signed({2'b00, cur_steps}) + $signed({{2{br_q[7]}}, br_q}))
    else $error("brake offset not applied");
  AST_POS_SUST: assert property (state_q == ST_CALC && cur_level > 0 && cur_level != max_q // [RL5]
    |-> cur_kind == KIND_POS_SUST && sum_d == $signed({2'b00, cur_steps}) + $signed({{2{ps_q[7]}}, ps_q}))
    else $error("positive sustain offset wrong");
  AST_NEG_SUST: assert property (state_q == ST_CALC && cur_level < 0 && cur_level != max_q // [RL7]
    && cur_level != min_q
    |-> cur_kind == KIND_NEG_SUST && sum_d == $signed({2'b00, cur_steps}) + $signed({{2{ns_q[7]}}, ns_q}))
    else $error("negative sustain offset wrong");
  AST_CLAMP: assert property (state_q == ST_CALC && sum_d <= 0 |=> !drive_active && state_q != ST_HOLD) // [RL12]
    else $error("non-positive segment was played");
  AST_STEP_TIME: assert property (state_q == ST_HOLD && left_q == ONE_STEP && cyc_q == 16'h0000 // [RL13]
    && step_cycles == 16'h0003 |-> drive_active [*3] ##1 !drive_active)
    else $error("step period not honoured");
endmodule : segment_time_offsets
`default_nettype wire

/* File: test/tb_segment_time_offsets.sv */
// Self-checking bench for the segment time offset block
`timescale 1ns/1ns
`default_nettype none
module tb_segment_time_offsets;
  import seg_offset_pkg::*;
  logic        clk_sys;
  logic        rstn;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid;
  logic        open_loop;
  logic [15:0] step_cycles;
  logic        seg_valid;
  logic        seg_ready;
  logic [7:0]  seg_level;
  logic [7:0]  seg_steps;
  logic        seg_last;
  logic        drive_active;
  logic [7:0]  drive_level;
  logic [2:0]  drive_kind;
  logic        play_done;
  int          miscompares;
  int          comparisons;
  int          cycles = 0;
  logic [7:0]  lv[$];
  logic [7:0]  st[$];
  int          exp_len[$];
  logic [2:0]  exp_kind[$];
  int          got_len[$];
  logic [2:0]  got_kind[$];
  logic [7:0]  exp_lvl[$];
  logic [7:0]  got_lvl[$];

  segment_time_offsets #(.DEPTH(SEG_DEPTH)) i_dut (
    .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .open_loop(open_loop), .step_cycles(step_cycles), .seg_valid(seg_valid),
    .seg_ready(seg_ready), .seg_level(seg_level), .seg_steps(seg_steps),
    .seg_last(seg_last), .drive_active(drive_active), .drive_level(drive_level),
    .drive_kind(drive_kind), .play_done(play_done));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic tally_and_finish();
    if (miscompares == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  // Hang guard, well above the longest playback
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %0t data %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk_runs();
    comparisons++;
    if (got_len.size() != exp_len.size()) begin
      miscompares++;
      $display("mismatch %0t %0d runs expected %0d", $time, got_len.size(), exp_len.size());
    end
    for (int i = 0; i < exp_len.size() && i < got_len.size(); i++) begin
      comparisons++;
      if (got_len[i] != exp_len[i] || got_kind[i] !== exp_kind[i] || got_lvl[i] !== exp_lvl[i]) begin
        miscompares++;
        $display("mismatch %0t run %0d len %0d kind %0d level %h", $time, i, got_len[i], got_kind[i], got_lvl[i]);
      end
    end
  endtask : chk_runs

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk8({7'h00, reg_rvalid}, 8'h01);
    chk8(reg_rdata, exp);
    @(posedge clk_sys);
  endtask : rd

  // Write then read the same register on the very next edge
  task automatic b2b_test();
    reg_addr  <= ADDR_OVERDRIVE;
    reg_wdata <= 8'h7e;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk8({7'h00, reg_rvalid}, 8'h01);
    chk8(reg_rdata, 8'h7e);
    @(posedge clk_sys);
  endtask : b2b_test

  // Load lv/st, then gather each drive_active run until play_done
  task automatic play();
    int   run;
    logic seen;
    got_len.delete();
    got_kind.delete();
    got_lvl.delete();
    run  = 0;
    seen = 1'b0;
    for (int i = 0; i < lv.size(); i++) begin
      seg_valid <= 1'b1;
      seg_level <= lv[i];
      seg_steps <= st[i];
      seg_last  <= (i == lv.size() - 1);
      @(posedge clk_sys);
    end
    seg_valid <= 1'b0;
    seg_last  <= 1'b0;
    for (int n = 0; n < 4000; n++) begin
      @(negedge clk_sys);
      if (n == 0) chk8({7'h00, seg_ready}, 8'h00);
      if (drive_active === 1'b1) begin
        if (run == 0) begin
          got_kind.push_back(drive_kind);
          got_lvl.push_back(drive_level);
        end
        run++;
      end else if (run > 0) begin
        got_len.push_back(run);
        run = 0;
      end
      if (play_done === 1'b1) begin
        chk8({7'h00, seg_ready}, 8'h01);
        seen = 1'b1;
        break;
      end
    end
    if (run > 0) got_len.push_back(run);
    // A playback that never ends must not pass
    chk8({7'h00, seen}, 8'h01);
    @(posedge clk_sys);
  endtask : play

  task automatic regs_test();
    rd(ADDR_OVERDRIVE, 8'h00);
    rd(ADDR_POS_SUST, 8'h00);
    rd(ADDR_NEG_SUST, 8'h00);
    rd(ADDR_BRAKE, 8'h00);
    b2b_test();
    wr(ADDR_OVERDRIVE, 8'h02);
    wr(ADDR_POS_SUST, 8'hff);
    wr(ADDR_NEG_SUST, 8'h01);
    wr(ADDR_BRAKE, 8'hff);
    wr(8'h11, 8'h5a);
    rd(ADDR_OVERDRIVE, 8'h02);
    rd(ADDR_POS_SUST, 8'hff);
    rd(ADDR_NEG_SUST, 8'h01);
    rd(ADDR_BRAKE, 8'hff);
    rd(8'h11, UNMAPPED_READ);
  endtask : regs_test

  // Peak, positive, negative, most negative, each step 3 cycles
  task automatic wave_test(input logic ol, input int od, input int br);
    open_loop   <= ol;
    step_cycles <= 16'h0003;
    lv = '{8'h7f, 8'h20, 8'he0, 8'h80};
    st = '{8'h02, 8'h03, 8'h02, 8'h03};
    exp_len  = '{od * 3, 6, 9, br * 3};
    exp_kind = '{3'h1, 3'h2, 3'h3, 3'h4};
    exp_lvl  = lv;
    play();
    chk_runs();
  endtask : wave_test

  // Positive sustain -3 empties a 3-step segment; step 0 acts as 1
  task automatic clamp_test();
    open_loop   <= 1'b1;
    step_cycles <= 16'h0000;
    wr(ADDR_POS_SUST, 8'hfd);
    lv = '{8'h50, 8'h10, 8'h08, 8'hc0};
    st = '{8'h01, 8'h03, 8'h05, 8'h02};
    exp_len  = '{3, 2, 1};
    exp_kind = '{3'h1, 3'h2, 3'h4};
    exp_lvl  = '{8'h50, 8'h08, 8'hc0};
    play();
    chk_runs();
  endtask : clamp_test

  initial begin
    miscompares = 0;
    comparisons = 0;
    rstn        = 1'b0;
    reg_addr    = 8'h00;
    reg_wdata   = 8'h00;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    open_loop   = 1'b1;
    step_cycles = 16'h0001;
    seg_valid   = 1'b0;
    seg_level   = 8'h00;
    seg_steps   = 8'h00;
    seg_last    = 1'b0;
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    regs_test();
    wave_test(1'b1, 4, 2);
    wave_test(1'b0, 2, 3);
    clamp_test();
    tally_and_finish();
  end
endmodule : tb_segment_time_offsets
`default_nettype wire
